// file: ifs_pkg.sv
// Constants and carrier types for the I2C format switch and flag block
package ifs_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] IFS_STC_OFF = 8'h00;
  localparam logic [7:0] IFS_FSC_OFF = 8'h04;
  localparam logic [7:0] IFS_MSC_OFF = 8'h08;
  localparam logic [7:0] IFS_STAT_OFF = 8'h0C;
  localparam logic [7:0] IFS_MODE_OFF = 8'h10;
  // ==========================================================
  // Field positions
  localparam int IFS_STC_ACC = 4;
  localparam int IFS_STC_X0 = 5;
  localparam int IFS_STC_X1 = 6;
  localparam int IFS_FSC_SWE = 7;
  localparam int IFS_FSC_SW = 6;
  localparam int IFS_FSC_IE = 5;
  localparam int IFS_FSC_IF = 4;
  localparam int IFS_MSC_CH0 = 4;
  localparam int IFS_MSC_CH1 = 3;
  localparam int IFS_MODE_CH1 = 4;
  // ==========================================================
  // Reset values and codes
  localparam logic [7:0] IFS_STC_RST = 8'h00;
  localparam logic [3:0] IFS_CLR_RD = 4'hF;
  localparam logic [1:0] IFS_MSTP_RST = 2'h3;
  localparam logic [2:0] IFS_CKS_RST = 3'h0;
  localparam logic [3:0] IFS_CLR_CH0 = 4'h5;
  localparam logic [3:0] IFS_CLR_CH1 = 4'hA;
  localparam logic [1:0] IFS_RESP_OK = 2'h0;
  localparam logic [1:0] IFS_RESP_ERR = 2'h2;
  // ==========================================================
  // Transfer states, Gray coded along the usual path
  typedef enum logic [3:0] {
    IFS_IDLE = 4'h0, IFS_STSET = 4'h1, IFS_STOK = 4'h3, IFS_MEND = 4'h2,
    IFS_MWAIT = 4'h6, IFS_ARBL = 4'h7, IFS_SADR = 4'h5, IFS_SGC = 4'h4,
    IFS_SADX = 4'hC, IFS_SEND = 4'hD, IFS_SENDX = 4'hF, IFS_STOPD = 4'hE
  } ifs_xst_t;
  // Status flags of channel 0, bit 11 down to bit 0
  typedef struct packed {
    logic transfer_irq_flag;
    logic master_select;
    logic transmit_select;
    logic bus_busy_flag;
    logic error_stop_flag;
    logic stop;
    logic continuous_transfer_flag;
    logic second_address_match;
    logic al;
    logic own_address_match;
    logic general_call_match;
    logic ack_bit;
  } ifs_stat_t;
  // One-cycle events from the shift engine of channel 0
  typedef struct packed {
    logic start_req;
    logic start_ok;
    logic wait_ins;
    logic xfer_end;
    logic addr1;
    logic addr2;
    logic gcall;
    logic stop_det;
    logic dtc_acc;
    logic dtc_done;
    logic rw;
    logic ack_bit;
  } ifs_evt_t;
endpackage

// file: ifs_ctrl.sv
// Control, format switch and status flags of a two-channel I2C interface
// Summary of operation
// - Arbitration lost when own SCL high at fall
// - Rate extension bit plus clock select field
// - Access enable gates interface register access
// - Formatless select picks channel 0 format
// - Formatless set only after read as zero
// - Formatless clears by write or SCL fall
// - Auto switch enable permits format change
// - Change flag sets on fall, read-then-zero clears
// - Change interrupt enable gates the flag
// - Latch clear bits write-only, read as one
// - Code 0101 clears channel 0 latch
// - Module stop bits reset to one
// - No continuous flag during first-address window
// - Count done clears empty/full, keeps flags
// - Idle state shows all flags zero
// - Start satisfied sets master, transmit, busy, continuous
// - Transfer end continuous set, wait clears it
// - First address match sets match and busy
// - General call sets call flag and ack
// - Second-address end sets continuous and match
// - Arbitration lost on data mismatch at rise
// - Setting formatless raises transfer interrupt flag
`timescale 1ns/1ps
`default_nettype none
module ifs_ctrl (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite write channels
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read channels
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // I2C pins, sampled only
  input wire logic scl_pin,
  input wire logic sda_pin,
  // Shift engine of channel 0
  input wire logic scl_drv,
  input wire logic sda_drv,
  input wire ifs_pkg::ifs_evt_t evt,
  // Control outputs
  output logic [3:0] rate_ch0,
  output logic [3:0] rate_ch1,
  output logic formatless_select,
  output logic [1:0] module_stop,
  output logic [1:0] latch_clr,
  output logic fmt_irq,
  output ifs_pkg::ifs_stat_t status,
  output logic tx_data_empty,
  output logic rx_data_full
);
  import ifs_pkg::*;

  // ==========================================================
  // Register state
  logic host_access_enable_q;
  logic rate_extend_ch0_q;
  logic rate_extend_ch1_q;
  logic auto_format_change_enable_q;
  logic format_change_irq_enable_q;
  logic format_change_flag_q;
  logic [2:0] clock_select_ch0_q;
  logic [2:0] clock_select_ch1_q;
  logic sw_arm_q;
  logic if_arm_q;
  logic [11:0] stat_arm_q;
  ifs_xst_t xst_q;
  ifs_xst_t xst_d;
  ifs_stat_t flags_d;

  // ==========================================================
  // Pin synchronisers and edge detect
  logic scl_s1_q, scl_s2_q, scl_s3_q;
  logic sda_s1_q, sda_s2_q;
  logic scl_fall, scl_rise;

  // Only the second and third stages feed logic, the first is metastable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {scl_s1_q, scl_s2_q, scl_s3_q} <= 3'h7;
      {sda_s1_q, sda_s2_q} <= 2'h3;
    end else if (ce) begin
      scl_s1_q <= scl_pin;
      scl_s2_q <= scl_s1_q;
      scl_s3_q <= scl_s2_q;
      sda_s1_q <= sda_pin;
      sda_s2_q <= sda_s1_q;
    end
  end

  assign scl_fall = scl_s3_q & ~scl_s2_q;
  assign scl_rise = ~scl_s3_q & scl_s2_q;

  // ==========================================================
  // AXI4-Lite write path
  logic aw_full_q, w_full_q;
  logic [7:0] wa_q;
  logic [31:0] wd_q;
  logic ws_q;
  logic wr_go, wr_ok;
  logic wr_stc, wr_fsc, wr_msc, wr_stat, wr_mode;

  // Address and data are held until both are here, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      aw_full_q <= 1'b0;
      wa_q <= 8'h00;
    end else if (ce) begin
      if (awvalid && awready) begin
        wa_q <= awaddr;
        aw_full_q <= 1'b1;
        awready <= 1'b0;
      end else if (wr_go) begin
        aw_full_q <= 1'b0;
        awready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready <= 1'b1;
      w_full_q <= 1'b0;
      wd_q <= 32'h0000_0000;
      ws_q <= 1'b0;
    end else if (ce) begin
      if (wvalid && wready) begin
        wd_q <= wdata;
        ws_q <= wstrb[0];
        w_full_q <= 1'b1;
        wready <= 1'b0;
      end else if (wr_go) begin
        w_full_q <= 1'b0;
        wready <= 1'b1;
      end
    end
  end

  // Interface registers are blocked while host access is off
  assign wr_go = aw_full_q & w_full_q & ~bvalid;
  assign wr_ok = (wa_q == IFS_STC_OFF) || (wa_q == IFS_FSC_OFF) ||
                 (wa_q == IFS_MSC_OFF) ||
                 (host_access_enable_q &&
                  ((wa_q == IFS_STAT_OFF) || (wa_q == IFS_MODE_OFF)));
  assign wr_stc = wr_go & ws_q & (wa_q == IFS_STC_OFF);
  assign wr_fsc = wr_go & ws_q & (wa_q == IFS_FSC_OFF);
  assign wr_msc = wr_go & ws_q & (wa_q == IFS_MSC_OFF);
  assign wr_stat = wr_go & ws_q & wr_ok & (wa_q == IFS_STAT_OFF);
  assign wr_mode = wr_go & ws_q & wr_ok & (wa_q == IFS_MODE_OFF);

  // Response one cycle after both halves are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= IFS_RESP_OK;
    end else if (ce) begin
      if (wr_go) begin
        bvalid <= 1'b1;
        bresp <= wr_ok ? IFS_RESP_OK : IFS_RESP_ERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // AXI4-Lite read path
  logic [31:0] rd_val;
  logic rd_ok, rd_go;

  // Latch clear bits always read as ones
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok = 1'b1;
    unique case (araddr)
      IFS_STC_OFF: begin
        rd_val[IFS_STC_ACC] = host_access_enable_q;
        rd_val[IFS_STC_X0] = rate_extend_ch0_q;
        rd_val[IFS_STC_X1] = rate_extend_ch1_q;
      end
      IFS_FSC_OFF: begin
        rd_val[IFS_FSC_SWE] = auto_format_change_enable_q;
        rd_val[IFS_FSC_SW] = formatless_select;
        rd_val[IFS_FSC_IE] = format_change_irq_enable_q;
        rd_val[IFS_FSC_IF] = format_change_flag_q;
        rd_val[3:0] = IFS_CLR_RD;
      end
      IFS_MSC_OFF: begin
        rd_val[IFS_MSC_CH0] = module_stop[0];
        rd_val[IFS_MSC_CH1] = module_stop[1];
      end
      IFS_STAT_OFF: begin
        rd_ok = host_access_enable_q;
        rd_val[11:0] = host_access_enable_q ? status : 12'h000;
      end
      IFS_MODE_OFF: begin
        rd_ok = host_access_enable_q;
        if (host_access_enable_q) begin
          rd_val[2:0] = clock_select_ch0_q;
          rd_val[IFS_MODE_CH1 +: 3] = clock_select_ch1_q;
        end
      end
      default: rd_ok = 1'b0;
    endcase
  end

  assign rd_go = arvalid & arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= IFS_RESP_OK;
    end else if (ce) begin
      if (rd_go) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= rd_val;
        rresp <= rd_ok ? IFS_RESP_OK : IFS_RESP_ERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // Reads arm the read-then-write clears and the formatless set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw_arm_q <= 1'b0;
      if_arm_q <= 1'b0;
      stat_arm_q <= 12'h000;
    end else if (ce) begin
      if (rd_go && araddr == IFS_FSC_OFF) begin
        sw_arm_q <= ~formatless_select;
        if_arm_q <= format_change_flag_q;
      end else if (wr_fsc) begin
        sw_arm_q <= 1'b0;
        if_arm_q <= 1'b0;
      end
      if (rd_go && araddr == IFS_STAT_OFF && host_access_enable_q)
        stat_arm_q <= status;
      else if (wr_stat)
        stat_arm_q <= 12'h000;
    end
  end

  // ==========================================================
  // Plain control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {rate_extend_ch1_q, rate_extend_ch0_q} <= IFS_STC_RST[1:0];
      host_access_enable_q <= IFS_STC_RST[IFS_STC_ACC];
    end else if (ce && wr_stc) begin
      host_access_enable_q <= wd_q[IFS_STC_ACC];
      rate_extend_ch0_q <= wd_q[IFS_STC_X0];
      rate_extend_ch1_q <= wd_q[IFS_STC_X1];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clock_select_ch0_q <= IFS_CKS_RST;
      clock_select_ch1_q <= IFS_CKS_RST;
    end else if (ce && wr_mode) begin
      clock_select_ch0_q <= wd_q[2:0];
      clock_select_ch1_q <= wd_q[IFS_MODE_CH1 +: 3];
    end
  end

  // Rate select is extension bit above the clock select field
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rate_ch0 <= {IFS_STC_RST[0], IFS_CKS_RST};
      rate_ch1 <= {IFS_STC_RST[0], IFS_CKS_RST};
    end else if (ce) begin
      rate_ch0 <= {rate_extend_ch0_q, clock_select_ch0_q};
      rate_ch1 <= {rate_extend_ch1_q, clock_select_ch1_q};
    end
  end

  // Both channels come out of reset stopped
  always_ff @(posedge aclk) begin
    if (!aresetn)
      module_stop <= IFS_MSTP_RST;
    else if (ce && wr_msc)
      module_stop <= {wd_q[IFS_MSC_CH1], wd_q[IFS_MSC_CH0]};
  end

  // Write data is not kept; only the two defined codes act
  always_ff @(posedge aclk) begin
    if (!aresetn)
      latch_clr <= 2'h0;
    else if (ce) begin
      latch_clr[0] <= wr_fsc && wd_q[3:0] == IFS_CLR_CH0;
      latch_clr[1] <= wr_fsc && wd_q[3:0] == IFS_CLR_CH1;
    end
  end

  // ==========================================================
  // Format switch of channel 0
  logic auto_fall, sw_set;

  assign auto_fall = scl_fall & auto_format_change_enable_q;
  assign sw_set = wr_fsc & wd_q[IFS_FSC_SW] & sw_arm_q & ~formatless_select & ~auto_fall;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      auto_format_change_enable_q <= 1'b0;
      format_change_irq_enable_q <= 1'b0;
    end else if (ce && wr_fsc) begin
      auto_format_change_enable_q <= wd_q[IFS_FSC_SWE];
      format_change_irq_enable_q <= wd_q[IFS_FSC_IE];
    end
  end

  // The bus edge wins over a software set in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn)
      formatless_select <= 1'b0;
    else if (ce) begin
      if (auto_fall)
        formatless_select <= 1'b0;
      else if (sw_set)
        formatless_select <= 1'b1;
      else if (wr_fsc && !wd_q[IFS_FSC_SW])
        formatless_select <= 1'b0;
    end
  end

  // A set arriving with the clearing write is kept
  always_ff @(posedge aclk) begin
    if (!aresetn)
      format_change_flag_q <= 1'b0;
    else if (ce) begin
      if (auto_fall)
        format_change_flag_q <= 1'b1;
      else if (wr_fsc && !wd_q[IFS_FSC_IF] && if_arm_q)
        format_change_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      fmt_irq <= 1'b0;
    else if (ce)
      fmt_irq <= format_change_flag_q & format_change_irq_enable_q;
  end

  // ==========================================================
  // Transfer state and status flags of channel 0
  logic run0, kill0, mtx, al_ev, ev_any;

  assign run0 = ~module_stop[0];
  assign kill0 = ~run0 | latch_clr[0];
  assign mtx = status.master_select & status.transmit_select;
  assign al_ev = mtx & ((scl_fall & scl_drv) |
                        (scl_rise & (sda_drv != sda_s2_q)));

  // Priority: arbitration, stop, start, address, wait, end
  always_comb begin
    xst_d = xst_q;
    if (al_ev) xst_d = IFS_ARBL;
    else if (evt.stop_det) xst_d = IFS_STOPD;
    else if (evt.start_ok) xst_d = IFS_STOK;
    else if (evt.start_req) xst_d = IFS_STSET;
    else if (evt.addr1) xst_d = IFS_SADR;
    else if (evt.addr2) xst_d = IFS_SADX;
    else if (evt.gcall) xst_d = IFS_SGC;
    else if (evt.wait_ins) xst_d = IFS_MWAIT;
    else if (evt.xfer_end) begin
      if (status.master_select) xst_d = IFS_MEND;
      else if (xst_q == IFS_SADX || xst_q == IFS_SENDX)
        xst_d = IFS_SENDX;
      else xst_d = IFS_SEND;
    end
  end

  // Flag pattern of each transfer state
  always_comb begin
    flags_d = '0;
    unique case (xst_d)
      IFS_IDLE: flags_d = '0;
      IFS_STSET: {flags_d.master_select, flags_d.transmit_select} = 2'h3;
      IFS_STOK: {flags_d.master_select, flags_d.transmit_select, flags_d.bus_busy_flag, flags_d.continuous_transfer_flag} = 4'hF;
      IFS_MWAIT, IFS_MEND: begin
        flags_d.master_select = 1'b1;
        flags_d.transmit_select = evt.rw;
        flags_d.bus_busy_flag = 1'b1;
        flags_d.ack_bit = evt.ack_bit;
        flags_d.continuous_transfer_flag = (xst_d == IFS_MEND);
      end
      IFS_ARBL: {flags_d.bus_busy_flag, flags_d.al} = 2'h3;
      IFS_SADR: {flags_d.bus_busy_flag, flags_d.own_address_match} = 2'h3;
      IFS_SGC: {flags_d.bus_busy_flag, flags_d.general_call_match, flags_d.ack_bit} = 3'h7;
      IFS_SADX: {flags_d.bus_busy_flag, flags_d.second_address_match} = 2'h3;
      IFS_SEND, IFS_SENDX: begin
        flags_d.transmit_select = evt.rw;
        flags_d.bus_busy_flag = 1'b1;
        flags_d.continuous_transfer_flag = (xst_d == IFS_SENDX);
        flags_d.second_address_match = (xst_d == IFS_SENDX);
        flags_d.ack_bit = evt.ack_bit & (xst_d == IFS_SEND);
      end
      IFS_STOPD: flags_d.stop = 1'b1;
      default: flags_d = '0;
    endcase
    flags_d.transfer_irq_flag = xst_d != IFS_STSET;
  end

  assign ev_any = al_ev | evt.stop_det | evt.start_ok | evt.start_req |
                  evt.addr1 | evt.addr2 | evt.gcall | evt.wait_ins | evt.xfer_end;

  always_ff @(posedge aclk) begin
    if (!aresetn)
      xst_q <= IFS_IDLE;
    else if (ce) begin
      if (kill0) xst_q <= IFS_IDLE;
      else if (ev_any && !formatless_select) xst_q <= xst_d;
    end
  end

  // New events win over software clears in the same cycle
  logic [11:0] clr_mask;
  always_comb begin
    clr_mask = wr_stat ? (stat_arm_q & ~wd_q[11:0]) : 12'h000;
    if (evt.dtc_acc) clr_mask[11] = 1'b1;
    if (clr_mask[11]) clr_mask[6] = 1'b1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      status <= '0;
    else if (ce) begin
      if (kill0)
        status <= '0;
      else if (ev_any && !formatless_select)
        status <= flags_d;
      else begin
        status <= status & ~clr_mask;
        if (sw_set) status.transfer_irq_flag <= 1'b1;
      end
    end
  end

  // Count done clears empty/full only; status flags stay set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_data_empty <= 1'b0;
      rx_data_full <= 1'b0;
    end else if (ce) begin
      if (kill0 || evt.dtc_done || evt.dtc_acc) begin
        tx_data_empty <= 1'b0;
        rx_data_full <= 1'b0;
      end else if (evt.xfer_end) begin
        tx_data_empty <= evt.rw;
        rx_data_full <= ~evt.rw;
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence fall_seen;
    ce && scl_fall && auto_format_change_enable_q;
  endsequence

  fmt_irq_out_a: assert property (
    ce && format_change_flag_q && format_change_irq_enable_q |=> fmt_irq)
    else $error("format change interrupt not raised");
  sw_auto_clr_a: assert property (fall_seen |=> !formatless_select)
    else $error("formatless select kept after SCL fall");
  flag_set_a: assert property (fall_seen |=> format_change_flag_q)
    else $error("format change flag not set");
  sw_set_a: assert property ($rose(formatless_select) |->
    $past(wr_fsc && sw_arm_q && wd_q[IFS_FSC_SW]))
    else $error("formatless select set without read as zero");
  start_ok_a: assert property (ce && !kill0 && evt.start_ok && !al_ev &&
    !evt.stop_det && !formatless_select |=> status == 12'hF20)
    else $error("start flags wrong");
  arb_lost_a: assert property (ce && !kill0 && al_ev &&
    !formatless_select |=> status.al && !status.master_select)
    else $error("arbitration loss not flagged");
  latch_clr_a: assert property (ce && wr_fsc && wd_q[3:0] == IFS_CLR_CH0
    |=> latch_clr[0] ##1 (!ce || status == 12'h000))
    else $error("channel 0 latch clear missing");
  stop_rst_a: assert property ($past(!aresetn) |-> module_stop == 2'h3)
    else $error("module stop not set after reset");
  dtc_done_a: assert property (ce && evt.dtc_done && !kill0 && !ev_any &&
    !wr_stat && !evt.dtc_acc && !sw_set |=> !tx_data_empty && !rx_data_full &&
    status.transfer_irq_flag == $past(status.transfer_irq_flag))
    else $error("count done handling wrong");
endmodule
`default_nettype wire

// file: ifs_bus_model.sv
// Bus-side model: I2C line levels and one-cycle shift engine events
`timescale 1ns/1ps
`default_nettype none
module ifs_bus_model (
  // Clock
  input wire logic aclk,
  // Line levels and engine side
  output logic scl_pin,
  output logic sda_pin,
  output logic scl_drv,
  output logic sda_drv,
  output ifs_pkg::ifs_evt_t evt
);
  import ifs_pkg::*;
  // Lines idle high through their pull-ups, own drive released
  initial begin
    scl_pin = 1'b1;
    sda_pin = 1'b1;
    scl_drv = 1'b1;
    sda_drv = 1'b1;
    evt = '0;
  end
  // One event pulse, exactly one cycle wide
  task automatic pulse(input ifs_evt_t e);
    @(posedge aclk);
    evt <= e;
    @(posedge aclk);
    evt <= '0;
  endtask
  // Another master pulls SCL low while own drive stays released
  // Held low long enough to pass the three-flop synchroniser
  task automatic fall();
    @(posedge aclk);
    scl_pin <= 1'b0;
    repeat (8) @(posedge aclk);
    scl_pin <= 1'b1;
    repeat (8) @(posedge aclk);
  endtask
endmodule
`default_nettype wire

// file: i2c_format_switch_and_flag_states_test.sv
// Self-checking testbench of the format switch and flag block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end
module i2c_format_switch_and_flag_states_test;
  import ifs_pkg::*;
  logic aclk = 0, aresetn = 0, ce = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
  logic rready = 0, awready, wready, bvalid, arready, rvalid, fmt_irq, formatless_select;
  logic tx_data_empty, rx_data_full, scl_pin, sda_pin, scl_drv, sda_drv;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, d, x;
  logic [3:0] wstrb = 4'hF, rate_ch0, rate_ch1;
  logic [1:0] bresp, rresp, module_stop, latch_clr, r;
  ifs_evt_t evt;
  ifs_stat_t status;
  int num_errors = 0, n_compared = 0, cyc = 0, n_lc = 0, lc0;
  // Status table: clear first, event, mask, expected
  logic clr[8] = '{1, 0, 0, 1, 0, 1, 1, 0};
  logic [11:0] ev[8] = '{12'h400, 12'h100, 12'h200, 12'h080,
                         12'h100, 12'h020, 12'h040, 12'h100};
  logic [11:0] mk[8] = '{12'h7FF, 12'h520, 12'h120, 12'h704,
                         12'h730, 12'h717, 12'h714, 12'h730};
  logic [11:0] ex[8] = '{12'h720, 12'h520, 12'h100, 12'h104,
                         12'h100, 12'h103, 12'h110, 12'h130};
  always #10 aclk = ~aclk;
  ifs_ctrl ifs_ctrl_i (.aclk(aclk), .aresetn(aresetn), .ce(ce), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .scl_pin(scl_pin), .sda_pin(sda_pin), .scl_drv(scl_drv),
    .sda_drv(sda_drv), .evt(evt), .rate_ch0(rate_ch0), .rate_ch1(rate_ch1),
    .formatless_select(formatless_select), .module_stop(module_stop),
    .latch_clr(latch_clr), .fmt_irq(fmt_irq), .status(status),
    .tx_data_empty(tx_data_empty), .rx_data_full(rx_data_full));
  ifs_bus_model ifs_bus_model_i (.aclk(aclk), .scl_pin(scl_pin), .sda_pin(sda_pin),
    .scl_drv(scl_drv), .sda_drv(sda_drv), .evt(evt));
  // ==========================================================
  // Counters: latch clear pulses and the hang guard
  always @(posedge aclk) begin
    if (latch_clr[0] === 1'b1) n_lc++;
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      results();
    end
  end
  // AXI4-Lite write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] dw, output logic [1:0] rs);
    logic dn;
    @(posedge aclk);
    awaddr <= a;
    wdata <= dw;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    dn = 0;
    while (!dn) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        rs = bresp;
        dn = 1;
      end
    end
    bready <= 1'b0;
  endtask
  // AXI4-Lite read, data taken at the edge where rvalid is seen
  task automatic rd(input logic [7:0] a, output logic [31:0] dr, output logic [1:0] rs);
    logic dn;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    dn = 0;
    while (!dn) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        dr = rdata;
        rs = rresp;
        dn = 1;
      end
    end
    rready <= 1'b0;
  endtask
  // Read and compare the masked word
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a, d, r);
    `CHK("register", e, d & m)
  endtask
  // Rate code expected from the extension bit and the clock select field
  function automatic logic [3:0] exp_rate(input logic ext, input logic [2:0] cks);
    return {ext, cks};
  endfunction
  // Verdict in one place
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(32'h9746180A));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    `CHK("module_stop", 2'h3, module_stop)
    rc(IFS_STC_OFF, 32'hFF, 32'h00);
    rc(IFS_FSC_OFF, 32'hFF, 32'h0F);
    rc(IFS_MSC_OFF, 32'hFF, 32'h18);
    rd(IFS_STAT_OFF, d, r);
    `CHK("gated", IFS_RESP_ERR, r)
    rd(8'h40, d, r);
    `CHK("unmapped", IFS_RESP_ERR, r)
    // Random rate fields, unused timer bits left zero by software
    repeat (3) begin
      x = $urandom;
      wr(IFS_STC_OFF, {25'h0, x[1:0], 1'b1, 4'h0}, r);
      wr(IFS_MODE_OFF, {25'h0, x[7:5], 1'b0, x[4:2]}, r);
      rc(IFS_STC_OFF, 32'h70, {25'h0, x[1:0], 1'b1, 4'h0});
      `CHK("rate_ch0", exp_rate(x[0], x[4:2]), rate_ch0)
      `CHK("rate_ch1", exp_rate(x[1], x[7:5]), rate_ch1)
    end
    wr(IFS_MSC_OFF, 32'h0, r);
    rc(IFS_MSC_OFF, 32'hFF, 32'h00);
    `CHK("module_stop", 2'h0, module_stop)
    // Formatless set after read as zero, then auto switch on SCL fall
    rd(IFS_FSC_OFF, d, r);
    wr(IFS_FSC_OFF, 32'hEF, r);
    repeat (2) @(posedge aclk);
    `CHK("formatless", 1'b1, formatless_select)
    `CHK("transfer_irq_flag", 1'b1, status.transfer_irq_flag)
    ifs_bus_model_i.fall();
    `CHK("formatless", 1'b0, formatless_select)
    `CHK("fmt_irq", 1'b1, fmt_irq)
    rc(IFS_FSC_OFF, 32'h7F, 32'h3F);
    wr(IFS_FSC_OFF, 32'h2F, r);
    ifs_bus_model_i.fall();
    rc(IFS_FSC_OFF, 32'hF0, 32'h20);
    `CHK("fmt_irq", 1'b0, fmt_irq)
    // Status per transfer state, latch clear before the cases marked in clr
    for (int i = 0; i < 8; i++) begin
      if (clr[i]) begin
        lc0 = n_lc;
        wr(IFS_FSC_OFF, 32'h25, r);
        repeat (2) @(posedge aclk);
        `CHK("latch_clr", lc0 + 1, n_lc)
        `CHK("status", 12'h000, status)
      end
      ifs_bus_model_i.pulse(ev[i]);
      repeat (2) @(posedge aclk);
      `CHK("status", ex[i], status & mk[i])
    end
    // Count done drops empty/full but keeps the transfer interrupt and continuous flags
    `CHK("rx_full", 1'b1, rx_data_full)
    ifs_bus_model_i.pulse(12'h004);
    repeat (2) @(posedge aclk);
    `CHK("rx_full", 1'b0, rx_data_full)
    `CHK("flags", 12'h820, status & 12'h820)
    // Arbitration lost: SCL falls while own clock is still high
    wr(IFS_FSC_OFF, 32'h25, r);
    ifs_bus_model_i.pulse(12'h400);
    ifs_bus_model_i.fall();
    `CHK("al", 1'b1, status.al)
    rc(IFS_STAT_OFF, 32'h008, 32'h008);
    // Clock enable low freezes the flags, a stop event included
    @(posedge aclk);
    ce <= 1'b0;
    ifs_bus_model_i.pulse(12'h010);
    repeat (2) @(posedge aclk);
    `CHK("frozen", 12'h908, status)
    ce <= 1'b1;
    results();
  end
endmodule
`default_nettype wire
